// ### src/opcode_map_pkg.sv
// opcode map constants and types for the instruction decoder
//
// Overview of operation
// - high opcode digit selects column zero to F
// - low digit selects register/memory operation
// - columns A-F fix mode and length, except AD and the illegal A7 and AC
// - implied one byte; literal two, operand second
// - indexed address: index, plus byte, plus word
// - full address: high then low byte
// - column 0: three-byte bit-test branches
// - column 1: two-byte page-zero bit writes
// - column 2 and AD: signed pc offset
// - read-modify-write columns: operand and operation
// - single-byte control opcodes decode individually
package opcode_map_pkg;

  // ****************************************
  // column numbers (high opcode digit)
  // ****************************************
  localparam logic [3:0] COL_BIT_BRANCH = 4'h0;
  localparam logic [3:0] COL_BIT_WRITE = 4'h1;
  localparam logic [3:0] COL_PC_BRANCH = 4'h2;
  localparam logic [3:0] COL_RMW_PAGE = 4'h3;
  localparam logic [3:0] COL_RMW_ACC = 4'h4;
  localparam logic [3:0] COL_RMW_IDX = 4'h5;
  localparam logic [3:0] COL_RMW_BYTE = 4'h6;
  localparam logic [3:0] COL_RMW_NOOFF = 4'h7;
  localparam logic [3:0] COL_CTRL_LO = 4'h8;
  localparam logic [3:0] COL_CTRL_HI = 4'h9;
  localparam logic [3:0] COL_LITERAL = 4'hA;
  localparam logic [3:0] COL_PAGE = 4'hB;
  localparam logic [3:0] COL_FULL = 4'hC;
  localparam logic [3:0] COL_WORD = 4'hD;
  localparam logic [3:0] COL_BYTE = 4'hE;
  localparam logic [3:0] COL_NOOFF = 4'hF;

  // ****************************************
  // special opcodes and field positions
  // ****************************************
  localparam logic [7:0] OPC_PRODUCT = 8'h42;
  localparam logic [7:0] OPC_REL_CALL = 8'hAD;
  localparam logic [7:0] OPC_LIT_HOLE_A = 8'hA7;
  localparam logic [7:0] OPC_LIT_HOLE_B = 8'hAC;
  localparam int BIT_NUM_LSB = 1;
  localparam int BIT_SENSE_POS = 0;
  localparam logic [7:0] PAGE_ZERO_HIGH = 8'h00;

  // ****************************************
  // instruction lengths and reset values
  // ****************************************
  localparam logic [1:0] LEN_ONE = 2'h1;
  localparam logic [1:0] LEN_TWO = 2'h2;
  localparam logic [1:0] LEN_THREE = 2'h3;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_ADDR = 16'h0000;

  // ****************************************
  // operations, modes, operand targets
  // ****************************************
  typedef enum logic [5:0] {
    OP_ILLEGAL, OP_MINUS_ACCUMULATOR, OP_COMPARE_ACCUMULATOR, OP_SUBTRACT_WITH_BORROW,
    OP_COMPARE_INDEX, OP_BITWISE_CONJUNCTION, OP_MASK_TEST, OP_LOAD_ACCUMULATOR,
    OP_STORE_ACCUMULATOR, OP_EXCLUSIVE_OR, OP_SUM_WITH_CARRY, OP_INCLUSIVE_OR, OP_SUM,
    OP_JUMP, OP_JUMP_TO_SUBROUTINE, OP_LOAD_INDEX, OP_STORE_INDEX,
    OP_TWOS_COMPLEMENT, OP_INVERT_BITS, OP_LOGICAL_SHIFT_RIGHT, OP_ROTATE_RIGHT,
    OP_ARITH_SHIFT_RIGHT, OP_SHIFT_LEFT, OP_ROTATE_LEFT, OP_MINUS_ONE, OP_PLUS_ONE,
    OP_ZERO_NEGATIVE_TEST, OP_ZERO_FILL,
    OP_BRANCH_IF_BIT_ONE, OP_BRANCH_IF_BIT_ZERO, OP_BIT_TO_ONE, OP_BIT_TO_ZERO,
    OP_BRANCH_RELATIVE, OP_RELATIVE_SUBROUTINE_CALL,
    OP_PRODUCT, OP_RETURN_FROM_INTERRUPT, OP_RETURN_FROM_SUBROUTINE, OP_SOFTWARE_TRAP,
    OP_STOP, OP_WAIT, OP_COPY_ACC_TO_INDEX, OP_CARRY_TO_ZERO, OP_CARRY_TO_ONE,
    OP_UNMASK_INTERRUPTS, OP_MASK_INTERRUPTS, OP_STACK_POINTER_INIT, OP_IDLE,
    OP_COPY_INDEX_TO_ACC
  } op_t;

  typedef enum logic [3:0] {
    MODE_IMPLIED, MODE_LITERAL_OPERAND, MODE_PAGE_ZERO, MODE_FULL_ADDRESS,
    MODE_INDEX_PLUS_WORD, MODE_INDEX_PLUS_BYTE, MODE_INDEXED_NO_OFFSET,
    MODE_PC_OFFSET, MODE_BIT_BRANCH
  } mode_t;

  typedef enum logic [1:0] {
    TGT_MEMORY, TGT_ACCUMULATOR, TGT_INDEX
  } target_t;

  typedef enum logic [2:0] {
    ST_OPCODE = 3'h1,
    ST_FIRST = 3'h2,
    ST_SECOND = 3'h4
  } state_t;

endpackage : opcode_map_pkg

// ### src/opcode_classifier.sv
// combinational opcode classifier: operation, mode, length, target
`timescale 1ns/1ps
`default_nettype none
module opcode_classifier
  import opcode_map_pkg::*;
(
  // opcode in
  input wire logic [7:0] opcode,
  // classification out
  output op_t operation,
  output mode_t addrMode,
  output logic [1:0] instrLength,
  output target_t operandTarget
);

  // ****************************************
  // lookup functions
  // ****************************************
  function automatic op_t regOp(input logic [3:0] row);
    case (row)
      4'h0: regOp = OP_MINUS_ACCUMULATOR;
      4'h1: regOp = OP_COMPARE_ACCUMULATOR;
      4'h2: regOp = OP_SUBTRACT_WITH_BORROW;
      4'h3: regOp = OP_COMPARE_INDEX;
      4'h4: regOp = OP_BITWISE_CONJUNCTION;
      4'h5: regOp = OP_MASK_TEST;
      4'h6: regOp = OP_LOAD_ACCUMULATOR;
      4'h7: regOp = OP_STORE_ACCUMULATOR;
      4'h8: regOp = OP_EXCLUSIVE_OR;
      4'h9: regOp = OP_SUM_WITH_CARRY;
      4'hA: regOp = OP_INCLUSIVE_OR;
      4'hB: regOp = OP_SUM;
      4'hC: regOp = OP_JUMP;
      4'hD: regOp = OP_JUMP_TO_SUBROUTINE;
      4'hE: regOp = OP_LOAD_INDEX;
      default: regOp = OP_STORE_INDEX;
    endcase
  endfunction : regOp

  function automatic op_t rmwOp(input logic [3:0] row);
    case (row)
      4'h0: rmwOp = OP_TWOS_COMPLEMENT;
      4'h3: rmwOp = OP_INVERT_BITS;
      4'h4: rmwOp = OP_LOGICAL_SHIFT_RIGHT;
      4'h6: rmwOp = OP_ROTATE_RIGHT;
      4'h7: rmwOp = OP_ARITH_SHIFT_RIGHT;
      4'h8: rmwOp = OP_SHIFT_LEFT;
      4'h9: rmwOp = OP_ROTATE_LEFT;
      4'hA: rmwOp = OP_MINUS_ONE;
      4'hC: rmwOp = OP_PLUS_ONE;
      4'hD: rmwOp = OP_ZERO_NEGATIVE_TEST;
      4'hF: rmwOp = OP_ZERO_FILL;
      default: rmwOp = OP_ILLEGAL;
    endcase
  endfunction : rmwOp

  function automatic op_t ctrlOp(input logic [7:0] opc);
    case (opc)
      8'h80: ctrlOp = OP_RETURN_FROM_INTERRUPT;
      8'h81: ctrlOp = OP_RETURN_FROM_SUBROUTINE;
      8'h83: ctrlOp = OP_SOFTWARE_TRAP;
      8'h8E: ctrlOp = OP_STOP;
      8'h8F: ctrlOp = OP_WAIT;
      8'h97: ctrlOp = OP_COPY_ACC_TO_INDEX;
      8'h98: ctrlOp = OP_CARRY_TO_ZERO;
      8'h99: ctrlOp = OP_CARRY_TO_ONE;
      8'h9A: ctrlOp = OP_UNMASK_INTERRUPTS;
      8'h9B: ctrlOp = OP_MASK_INTERRUPTS;
      8'h9C: ctrlOp = OP_STACK_POINTER_INIT;
      8'h9D: ctrlOp = OP_IDLE;
      8'h9F: ctrlOp = OP_COPY_INDEX_TO_ACC;
      default: ctrlOp = OP_ILLEGAL;
    endcase
  endfunction : ctrlOp

  function automatic op_t classifyOp(input logic [7:0] opc);
    case (opc[7:4])
      COL_BIT_BRANCH:
        classifyOp = opc[BIT_SENSE_POS] ? OP_BRANCH_IF_BIT_ZERO : OP_BRANCH_IF_BIT_ONE;
      COL_BIT_WRITE:
        classifyOp = opc[BIT_SENSE_POS] ? OP_BIT_TO_ZERO : OP_BIT_TO_ONE;
      COL_PC_BRANCH: classifyOp = OP_BRANCH_RELATIVE;
      COL_RMW_PAGE, COL_RMW_ACC, COL_RMW_IDX, COL_RMW_BYTE, COL_RMW_NOOFF:
        classifyOp = (opc == OPC_PRODUCT) ? OP_PRODUCT : rmwOp(opc[3:0]);
      COL_CTRL_LO, COL_CTRL_HI: classifyOp = ctrlOp(opc);
      COL_LITERAL:
        if (opc == OPC_REL_CALL)
          classifyOp = OP_RELATIVE_SUBROUTINE_CALL;
        else if (opc == OPC_LIT_HOLE_A || opc == OPC_LIT_HOLE_B)
          classifyOp = OP_ILLEGAL;
        else
          classifyOp = regOp(opc[3:0]);
      default: classifyOp = regOp(opc[3:0]);
    endcase
  endfunction : classifyOp

  function automatic mode_t classifyMode(input logic [7:0] opc);
    case (opc[7:4])
      COL_BIT_BRANCH: classifyMode = MODE_BIT_BRANCH;
      COL_BIT_WRITE, COL_RMW_PAGE, COL_PAGE: classifyMode = MODE_PAGE_ZERO;
      COL_PC_BRANCH: classifyMode = MODE_PC_OFFSET;
      COL_RMW_BYTE, COL_BYTE: classifyMode = MODE_INDEX_PLUS_BYTE;
      COL_RMW_NOOFF, COL_NOOFF: classifyMode = MODE_INDEXED_NO_OFFSET;
      COL_LITERAL:
        classifyMode = (opc == OPC_REL_CALL) ? MODE_PC_OFFSET : MODE_LITERAL_OPERAND;
      COL_FULL: classifyMode = MODE_FULL_ADDRESS;
      COL_WORD: classifyMode = MODE_INDEX_PLUS_WORD;
      default: classifyMode = MODE_IMPLIED;
    endcase
  endfunction : classifyMode

  function automatic logic [1:0] modeLength(input mode_t m);
    case (m)
      MODE_LITERAL_OPERAND, MODE_PAGE_ZERO, MODE_INDEX_PLUS_BYTE, MODE_PC_OFFSET:
        modeLength = LEN_TWO;
      MODE_FULL_ADDRESS, MODE_INDEX_PLUS_WORD, MODE_BIT_BRANCH: modeLength = LEN_THREE;
      default: modeLength = LEN_ONE;
    endcase
  endfunction : modeLength

  // ****************************************
  // classification
  // ****************************************
  wire op_t rawOp = classifyOp(opcode);
  wire logic isIllegal = (rawOp == OP_ILLEGAL);
  wire mode_t rawMode = classifyMode(opcode);

  assign operation = rawOp;
  assign addrMode = isIllegal ? MODE_IMPLIED : rawMode;
  assign instrLength = isIllegal ? LEN_ONE : modeLength(rawMode);
  assign operandTarget = (opcode[7:4] == COL_RMW_ACC && !isIllegal) ? TGT_ACCUMULATOR :
                         (opcode[7:4] == COL_RMW_IDX && !isIllegal) ? TGT_INDEX :
                         TGT_MEMORY;

endmodule : opcode_classifier
`default_nettype wire

// ### src/opcode_map_decoder.sv
// instruction decoder: opcode fetch, operand fetch, address formation
`timescale 1ns/1ps
`default_nettype none
module opcode_map_decoder
  import opcode_map_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // program memory byte stream
  input wire logic byteValid,
  input wire logic [7:0] byteData,
  // core index register
  input wire logic [7:0] indexReg,
  // decoded instruction
  output logic expectOpcode,
  output logic instrValid,
  output logic [7:0] opcode,
  output op_t operation,
  output mode_t addrMode,
  output logic [1:0] instrLength,
  output target_t operandTarget,
  output logic [2:0] bitNumber,
  output logic illegal,
  output logic [7:0] operandValue,
  output logic [7:0] relOffset,
  output logic [15:0] effAddr
);

  // ****************************************
  // address formation
  // ****************************************
  function automatic logic [15:0] formAddr(input mode_t m, input logic [7:0] b1,
                                           input logic [7:0] b2, input logic [7:0] idx);
    case (m)
      MODE_PAGE_ZERO, MODE_BIT_BRANCH: formAddr = {PAGE_ZERO_HIGH, b1};
      MODE_FULL_ADDRESS: formAddr = {b1, b2};
      MODE_INDEX_PLUS_WORD: formAddr = {b1, b2} + {PAGE_ZERO_HIGH, idx};
      MODE_INDEX_PLUS_BYTE: formAddr = {PAGE_ZERO_HIGH, b1} + {PAGE_ZERO_HIGH, idx};
      MODE_INDEXED_NO_OFFSET: formAddr = {PAGE_ZERO_HIGH, idx};
      default: formAddr = RST_ADDR;
    endcase
  endfunction : formAddr

  // ****************************************
  // registers
  // ****************************************
  state_t state_ff;
  logic expect_ff;
  logic valid_ff;
  logic [7:0] opcode_ff;
  op_t op_ff;
  mode_t mode_ff;
  logic [1:0] len_ff;
  target_t target_ff;
  logic [2:0] bit_ff;
  logic illegal_ff;
  logic [7:0] firstByte_ff;
  logic [7:0] operand_ff;
  logic [7:0] rel_ff;
  logic [15:0] addr_ff;

  // ****************************************
  // classifier on the incoming opcode byte
  // ****************************************
  op_t clsOp;
  mode_t clsMode;
  logic [1:0] clsLength;
  target_t clsTarget;

  opcode_classifier u_classifier (
    .opcode(byteData),
    .operation(clsOp),
    .addrMode(clsMode),
    .instrLength(clsLength),
    .operandTarget(clsTarget)
  );

  // ****************************************
  // sequencing
  // ****************************************
  wire logic takeOpcode = byteValid && (state_ff == ST_OPCODE);
  wire logic takeFirst = byteValid && (state_ff == ST_FIRST);
  wire logic takeSecond = byteValid && (state_ff == ST_SECOND);
  wire logic done = (takeOpcode && clsLength == LEN_ONE) ||
                    (takeFirst && len_ff == LEN_TWO) || takeSecond;
  wire mode_t curMode = (state_ff == ST_OPCODE) ? clsMode : mode_ff;
  wire logic [7:0] curFirst = takeFirst ? byteData : firstByte_ff;
  wire logic [7:0] curFirstSel = takeOpcode ? RST_BYTE : curFirst;
  wire logic [7:0] curSecond = takeSecond ? byteData : RST_BYTE;
  wire logic [7:0] nxt_rel = (curMode == MODE_BIT_BRANCH) ? curSecond : curFirstSel;
  wire logic [15:0] nxt_addr = formAddr(curMode, curFirstSel, curSecond, indexReg);

  state_t nxt_state;
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_OPCODE:
        if (byteValid && clsLength != LEN_ONE)
          nxt_state = ST_FIRST;
      ST_FIRST:
        if (byteValid)
          nxt_state = (len_ff == LEN_THREE) ? ST_SECOND : ST_OPCODE;
      ST_SECOND:
        if (byteValid)
          nxt_state = ST_OPCODE;
      default: nxt_state = ST_OPCODE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_ff <= ST_OPCODE;
      expect_ff <= 1'b1;
      valid_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      expect_ff <= (nxt_state == ST_OPCODE);
      valid_ff <= done;
    end
  end

  // opcode-time fields
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      opcode_ff <= RST_BYTE;
      op_ff <= OP_ILLEGAL;
      mode_ff <= MODE_IMPLIED;
      len_ff <= LEN_ONE;
      target_ff <= TGT_MEMORY;
      bit_ff <= 3'h0;
      illegal_ff <= 1'b0;
    end
    else if (takeOpcode)
    begin
      opcode_ff <= byteData;
      op_ff <= clsOp;
      mode_ff <= clsMode;
      len_ff <= clsLength;
      target_ff <= clsTarget;
      bit_ff <= byteData[BIT_NUM_LSB +: 3];
      illegal_ff <= (clsOp == OP_ILLEGAL);
    end
  end

  // operand-time fields
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      firstByte_ff <= RST_BYTE;
      operand_ff <= RST_BYTE;
      rel_ff <= RST_BYTE;
      addr_ff <= RST_ADDR;
    end
    else
    begin
      if (takeFirst)
        firstByte_ff <= byteData;
      if (done)
      begin
        operand_ff <= curFirstSel;
        rel_ff <= nxt_rel;
        addr_ff <= nxt_addr;
      end
    end
  end

  assign expectOpcode = expect_ff;
  assign instrValid = valid_ff;
  assign opcode = opcode_ff;
  assign operation = op_ff;
  assign addrMode = mode_ff;
  assign instrLength = len_ff;
  assign operandTarget = target_ff;
  assign bitNumber = bit_ff;
  assign illegal = illegal_ff;
  assign operandValue = operand_ff;
  assign relOffset = rel_ff;
  assign effAddr = addr_ff;

  // ****************************************
  // assertions
  // ****************************************
  a_implied_single: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    takeOpcode && clsMode == MODE_IMPLIED |=> instrValid && expectOpcode && instrLength == 1)
    else $error("implied opcode did not finish in one byte");

  a_literal_operand: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    instrValid && addrMode == MODE_LITERAL_OPERAND
      |-> instrLength == 2 && operandValue == $past(byteData))
    else $error("literal operand not taken from second byte");

  a_full_concat: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    instrValid && addrMode == MODE_FULL_ADDRESS
      |-> effAddr == {$past(firstByte_ff), $past(byteData)} && instrLength == 3)
    else $error("full address not high then low byte");

  a_index_only: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    instrValid && addrMode == MODE_INDEXED_NO_OFFSET |-> effAddr == {8'h00, $past(indexReg)})
    else $error("indexed address differs from index register");

  a_index_byte_sum: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    instrValid && addrMode == MODE_INDEX_PLUS_BYTE
      |-> effAddr == 16'({8'h00, $past(byteData)} + {8'h00, $past(indexReg)}))
    else $error("index plus byte address wrong");

  a_bit_branch_form: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    instrValid && opcode[7:4] == COL_BIT_BRANCH
      |-> instrLength == 3 && bitNumber == opcode[3:1] && relOffset == $past(byteData)
          && effAddr == {8'h00, $past(firstByte_ff)})
    else $error("bit-test branch decoded wrongly");

  a_bit_write_form: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    instrValid && opcode[7:4] == COL_BIT_WRITE
      |-> instrLength == 2 && operation == (opcode[0] ? OP_BIT_TO_ZERO : OP_BIT_TO_ONE))
    else $error("bit write decoded wrongly");

  a_pc_offset_form: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    instrValid && (opcode[7:4] == COL_PC_BRANCH || opcode == OPC_REL_CALL)
      |-> addrMode == MODE_PC_OFFSET && instrLength == 2 && relOffset == $past(byteData))
    else $error("pc offset branch decoded wrongly");

  a_rmw_acc_target: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    instrValid && opcode[7:4] == COL_RMW_ACC && !illegal && opcode != OPC_PRODUCT
      |-> operandTarget == TGT_ACCUMULATOR && instrLength == 1)
    else $error("accumulator read-modify-write wrong");

  a_illegal_flag: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    instrValid && illegal |-> operation == OP_ILLEGAL && instrLength == 1 && expectOpcode)
    else $error("illegal opcode not flagged as one byte");

  a_expect_drop: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    takeOpcode && clsLength != LEN_ONE |=> !expectOpcode && !instrValid)
    else $error("operand bytes not awaited");

  a_index_word_sum: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    instrValid && addrMode == MODE_INDEX_PLUS_WORD
      |-> effAddr == 16'({$past(firstByte_ff), $past(byteData)} + {8'h00, $past(indexReg)}))
    else $error("index plus word address wrong");

  a_page_zero_addr: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    instrValid && addrMode == MODE_PAGE_ZERO
      |-> effAddr == {8'h00, $past(byteData)} && instrLength == 2)
    else $error("page zero address wrong");

  a_byte_column: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    instrValid && opcode[7:4] == COL_BYTE
      |-> addrMode == MODE_INDEX_PLUS_BYTE && instrLength == 2)
    else $error("index plus byte column wrong");

  a_full_column: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    instrValid && opcode[7:4] == COL_FULL
      |-> addrMode == MODE_FULL_ADDRESS && operation != OP_ILLEGAL)
    else $error("full address column wrong");

  a_rmw_idx_target: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    instrValid && opcode[7:4] == COL_RMW_IDX && !illegal
      |-> operandTarget == TGT_INDEX && instrLength == 1)
    else $error("index read-modify-write wrong");

  a_ctrl_single: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    instrValid && (opcode[7:4] == COL_CTRL_LO || opcode[7:4] == COL_CTRL_HI)
      |-> instrLength == 1 && addrMode == MODE_IMPLIED && operandValue == 8'h00)
    else $error("control opcode not single byte");

  a_bit_write_addr: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    instrValid && opcode[7:4] == COL_BIT_WRITE
      |-> bitNumber == opcode[3:1] && effAddr == {8'h00, $past(byteData)})
    else $error("bit write address wrong");

  a_product_implied: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    instrValid && opcode == OPC_PRODUCT
      |-> operation == OP_PRODUCT && instrLength == 1 && !illegal)
    else $error("product opcode wrong");

endmodule : opcode_map_decoder
`default_nettype wire

// ### verification/prog_mem_model.sv
// program memory model feeding opcode and operand bytes
`timescale 1ns/1ps
`default_nettype none
module prog_mem_model
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // pacing
  input wire logic stallEn,
  // byte stream
  output logic byteValid,
  output logic [7:0] byteData
);
  logic [7:0] byteQ[$];
  int seed = 56296;

  task automatic push(input logic [7:0] b);
    byteQ.push_back(b);
  endtask : push

  function automatic int pending();
    return byteQ.size();
  endfunction : pending

  initial
  begin
    byteValid = 1'b0;
    byteData = 8'hA5;
  end

  // idle bus inverts its byte every cycle, so every second idle cycle repeats the last byte
  always @(posedge sys_clk)
  begin
    #1;
    if (!rst_n)
      byteQ.delete();
    if (!rst_n || byteQ.size() == 0 || (stallEn && $random(seed) % 2 != 0))
    begin
      byteValid <= 1'b0;
      byteData <= ~byteData;
    end
    else
    begin
      byteValid <= 1'b1;
      byteData <= byteQ.pop_front();
    end
  end
endmodule : prog_mem_model
`default_nettype wire

// ### verification/tb_opcode_map_decoder.sv
// self-checking testbench for the opcode map decoder
`timescale 1ns/1ps
`default_nettype none
module tb_opcode_map_decoder
  import opcode_map_pkg::*;
;
  typedef struct packed {logic [7:0] o; logic [7:0] b1; logic [7:0] b2; logic [7:0] x;} instr_t;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic stallEn = 1'b0;
  logic [7:0] indexReg = 8'h00;
  logic byteValid, expectOpcode, instrValid, illegal;
  logic [7:0] byteData, opcode, operandValue, relOffset;
  logic [1:0] instrLength, eLen;
  logic [2:0] bitNumber;
  logic [15:0] effAddr;
  op_t operation, eOp;
  mode_t addrMode, eMode;
  target_t operandTarget, eTgt;
  instr_t expQ[$];
  instr_t cur;
  int err_total = 0;
  int checks = 0;
  int seed = 56296;
  mode_t colMode [16] = '{MODE_BIT_BRANCH, MODE_PAGE_ZERO, MODE_PC_OFFSET, MODE_PAGE_ZERO,
    MODE_IMPLIED, MODE_IMPLIED, MODE_INDEX_PLUS_BYTE, MODE_INDEXED_NO_OFFSET, MODE_IMPLIED,
    MODE_IMPLIED, MODE_LITERAL_OPERAND, MODE_PAGE_ZERO, MODE_FULL_ADDRESS,
    MODE_INDEX_PLUS_WORD, MODE_INDEX_PLUS_BYTE, MODE_INDEXED_NO_OFFSET};
  logic [1:0] colLen [16] = '{2'h3, 2'h2, 2'h2, 2'h2, 2'h1, 2'h1, 2'h2, 2'h1, 2'h1, 2'h1,
    2'h2, 2'h2, 2'h3, 2'h3, 2'h2, 2'h1};

  always #5 sys_clk = ~sys_clk;

  prog_mem_model pmem (.sys_clk(sys_clk), .rst_n(rst_n), .stallEn(stallEn),
    .byteValid(byteValid), .byteData(byteData));

  opcode_map_decoder dut (.sys_clk(sys_clk), .rst_n(rst_n), .byteValid(byteValid),
    .byteData(byteData), .indexReg(indexReg), .expectOpcode(expectOpcode),
    .instrValid(instrValid), .opcode(opcode), .operation(operation), .addrMode(addrMode),
    .instrLength(instrLength), .operandTarget(operandTarget), .bitNumber(bitNumber),
    .illegal(illegal), .operandValue(operandValue), .relOffset(relOffset), .effAddr(effAddr));

  // ****************************************
  // expected decode
  // ****************************************
  function automatic void expect_of(input logic [7:0] o, output op_t op, output mode_t md,
                                    output logic [1:0] ln);
    logic [3:0] h;
    logic [3:0] l;
    h = o[7:4];
    l = o[3:0];
    op = OP_ILLEGAL;
    md = colMode[h];
    ln = colLen[h];
    if (h == 4'h0)
      op = l[0] ? OP_BRANCH_IF_BIT_ZERO : OP_BRANCH_IF_BIT_ONE;
    else if (h == 4'h1)
      op = l[0] ? OP_BIT_TO_ZERO : OP_BIT_TO_ONE;
    else if (h == 4'h2)
      op = OP_BRANCH_RELATIVE;
    else if (h >= 4'hA)
      op = op_t'(int'(OP_MINUS_ACCUMULATOR) + int'(l));
    else if (h == 4'h8)
      case (l)
        4'h0: op = OP_RETURN_FROM_INTERRUPT;
        4'h1: op = OP_RETURN_FROM_SUBROUTINE;
        4'h3: op = OP_SOFTWARE_TRAP;
        4'hE: op = OP_STOP;
        4'hF: op = OP_WAIT;
        default: op = OP_ILLEGAL;
      endcase
    else if (h == 4'h9)
    begin
      if (l >= 4'h7 && l <= 4'hD)
        op = op_t'(int'(OP_COPY_ACC_TO_INDEX) + int'(l) - 7);
      else if (l == 4'hF)
        op = OP_COPY_INDEX_TO_ACC;
    end
    else
      case (l)
        4'h0: op = OP_TWOS_COMPLEMENT;
        4'h3: op = OP_INVERT_BITS;
        4'h4: op = OP_LOGICAL_SHIFT_RIGHT;
        4'h6: op = OP_ROTATE_RIGHT;
        4'h7: op = OP_ARITH_SHIFT_RIGHT;
        4'h8: op = OP_SHIFT_LEFT;
        4'h9: op = OP_ROTATE_LEFT;
        4'hA: op = OP_MINUS_ONE;
        4'hC: op = OP_PLUS_ONE;
        4'hD: op = OP_ZERO_NEGATIVE_TEST;
        4'hF: op = OP_ZERO_FILL;
        default: op = OP_ILLEGAL;
      endcase
    if (o == 8'h42)
      op = OP_PRODUCT;
    if (o == 8'hA7 || o == 8'hAC)
      op = OP_ILLEGAL;
    if (o == 8'hAD)
    begin
      op = OP_RELATIVE_SUBROUTINE_CALL;
      md = MODE_PC_OFFSET;
      ln = 2'h2;
    end
    if (op == OP_ILLEGAL || o == 8'h42)
    begin
      md = MODE_IMPLIED;
      ln = 2'h1;
    end
  endfunction : expect_of

  function automatic logic [15:0] addr_of(input mode_t md, input logic [7:0] b1,
                                          input logic [7:0] b2, input logic [7:0] x);
    case (md)
      MODE_PAGE_ZERO, MODE_BIT_BRANCH: return {8'h00, b1};
      MODE_FULL_ADDRESS: return {b1, b2};
      MODE_INDEX_PLUS_WORD: return {b1, b2} + {8'h00, x};
      MODE_INDEX_PLUS_BYTE: return {8'h00, b1} + {8'h00, x};
      MODE_INDEXED_NO_OFFSET: return {8'h00, x};
      default: return 16'h0000;
    endcase
  endfunction : addr_of

  // ****************************************
  // tasks
  // ****************************************
  task automatic miss(input string m);
    err_total++;
    $display("mismatch at %0t: %s", $time, m);
  endtask : miss

  task automatic finish_test();
    if (err_total == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : finish_test

  task automatic send(input logic [7:0] o, input logic [7:0] b1, input logic [7:0] b2);
    instr_t e;
    op_t op;
    mode_t md;
    logic [1:0] ln;
    e = '{o, b1, b2, indexReg};
    expect_of(o, op, md, ln);
    expQ.push_back(e);
    pmem.push(o);
    if (ln > 2'h1)
      pmem.push(b1);
    if (ln > 2'h2)
      pmem.push(b2);
  endtask : send

  task automatic send_rand(input logic [7:0] o);
    send(o, 8'($random(seed)), 8'($random(seed)));
  endtask : send_rand

  task automatic drain();
    int n;
    for (n = 0; n < 4000 && expQ.size() != 0; n++)
      @(posedge sys_clk);
    if (expQ.size() != 0)
    begin
      miss("completion timeout");
      finish_test();
    end
    @(posedge sys_clk);
    #1;
  endtask : drain

  // ****************************************
  // completion monitor
  // ****************************************
  always @(negedge sys_clk)
    if (rst_n && instrValid === 1'b1)
    begin
      if (expQ.size() == 0)
        miss("unexpected completion");
      else
      begin
        cur = expQ.pop_front();
        expect_of(cur.o, eOp, eMode, eLen);
        eTgt = cur.o[7:4] == 4'h4 ? TGT_ACCUMULATOR : cur.o[7:4] == 4'h5 ? TGT_INDEX : TGT_MEMORY;
        checks += 11;
        if (opcode !== cur.o) miss("opcode");
        if (operation !== eOp) miss("operation");
        if (addrMode !== eMode) miss("mode");
        if (instrLength !== eLen) miss("length");
        if (illegal !== (eOp == OP_ILLEGAL)) miss("illegal flag");
        if (operandValue !== (eLen > 2'h1 ? cur.b1 : 8'h00)) miss("operand");
        if (effAddr !== addr_of(eMode, cur.b1, cur.b2, cur.x)) miss("address");
        if (cur.o[7:5] == 3'h0 && bitNumber !== cur.o[3:1]) miss("bit number");
        if (eMode == MODE_BIT_BRANCH && relOffset !== cur.b2) miss("branch offset");
        if (eMode == MODE_PC_OFFSET && relOffset !== cur.b1) miss("pc offset");
        if (eOp != OP_ILLEGAL && cur.o != 8'h42 && operandTarget !== eTgt) miss("target");
        if (expectOpcode !== 1'b1) miss("not back at opcode");
      end
    end

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    int i;
    repeat (2) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    for (int p = 0; p < 2; p++)
    begin
      stallEn = p[0];
      indexReg = 8'($random(seed));
      for (i = 0; i < 256; i++)
        send_rand(i[7:0]);
      drain();
    end
    indexReg = 8'hFF;
    send(8'hE6, 8'hFF, 8'h00);
    send(8'hD6, 8'hFF, 8'hFF);
    send(8'hC6, 8'h12, 8'h34);
    send(8'h0F, 8'h80, 8'h7F);
    send(8'hAD, 8'h80, 8'h00);
    send(8'hA7, 8'h11, 8'h22);
    drain();
    stallEn = 1'b1;
    for (i = 0; i < 300; i++)
      send_rand(8'($random(seed)));
    drain();
    stallEn = 1'b0;
    pmem.push(8'hC6);
    pmem.push(8'h12);
    repeat (4) @(posedge sys_clk);
    #1;
    rst_n = 1'b0;
    #2;
    checks++;
    if (expectOpcode !== 1'b1 || instrValid !== 1'b0 || operation !== OP_ILLEGAL
        || instrLength !== 2'h1) miss("reset values");
    repeat (2) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    send(8'h9D, 8'h00, 8'h00);
    drain();
    finish_test();
  end
endmodule : tb_opcode_map_decoder
`default_nettype wire
